// ### hdl/t8p_pkg.sv
// Package with register map, field layout and types of the eight-bit timer.
package t8p_pkg;
	localparam int          T8P_AW         = 3;
	localparam int          T8P_DW         = 8;
	localparam logic [2:0]  A_CONTROL      = 3'h0;
	localparam logic [2:0]  A_COUNT        = 3'h1;
	localparam logic [2:0]  A_COMPARE      = 3'h2;
	localparam logic [2:0]  A_IRQ_MASK     = 3'h3;
	localparam logic [2:0]  A_IRQ_FLAGS    = 3'h4;
	localparam logic [7:0]  CONTROL_RESET  = 8'h00;
	localparam logic [7:0]  COUNT_RESET    = 8'h00;
	localparam logic [7:0]  COMPARE_RESET  = 8'h00;
	localparam logic [1:0]  MASK_RESET     = 2'h0;
	localparam logic [1:0]  FLAGS_RESET    = 2'h0;
	localparam int          BIT_OVF        = 0;
	localparam int          BIT_CMP        = 1;
	localparam logic [7:0]  COUNT_MAX      = 8'hff;
	localparam logic [7:0]  COUNT_BOTTOM   = 8'h00;
	localparam int          PSC_W          = 10;
	localparam int          TAP_DIV8       = 3;
	localparam int          TAP_DIV64      = 6;
	localparam int          TAP_DIV256     = 8;
	localparam int          TAP_DIV1024    = 10;
	localparam logic [1:0]  COM_OFF        = 2'h0;
	localparam logic [1:0]  COM_TOGGLE     = 2'h1;
	localparam logic [1:0]  COM_CLEAR      = 2'h2;
	localparam logic [1:0]  COM_SET        = 2'h3;
	localparam logic [2:0]  CS_STOP        = 3'h0;
	localparam logic [2:0]  CS_DIV1        = 3'h1;
	localparam logic [2:0]  CS_DIV8        = 3'h2;
	localparam logic [2:0]  CS_DIV64       = 3'h3;
	localparam logic [2:0]  CS_DIV256      = 3'h4;
	localparam logic [2:0]  CS_DIV1024     = 3'h5;
	localparam logic [2:0]  CS_EXT_FALL    = 3'h6;
	localparam logic [2:0]  CS_EXT_RISE    = 3'h7;

	typedef enum logic [1:0] {
		MODE_NORMAL   = 2'h0,
		MODE_PC_PWM   = 2'h1,
		MODE_CLR_ON_M = 2'h2,
		MODE_FAST_PWM = 2'h3
	} t8p_mode_t;

	typedef enum logic {
		DIR_UP   = 1'b0,
		DIR_DOWN = 1'b1
	} t8p_dir_t;

	typedef struct packed {
		logic       force_compare_strobe;
		logic       wgm_lo;
		logic [1:0] compare_output_mode;
		logic       wgm_hi;
		logic [2:0] tick_source_sel;
	} t8p_ctrl_t;
endpackage

// ### hdl/t8p_timer.sv
// Eight-bit timer/counter with one compare channel, PWM modes and register port.
// Overview of operation
// - Counter is synchronous to i_mclk, stepping only on timer tick enables.
// - Force-compare bit 7 acts only in non-PWM modes.
// - Force strobe applies the compare action chosen by the output mode at once.
// - Forced compare sets no flag, never clears counter, reads back zero.
// - Mode bits 6 and 3 select normal, phase-correct, clear-on-match, fast PWM.
// - Compare update timing and overflow point depend on the mode.
// - Nonzero output mode hands the pin to the waveform; direction bit enables driver.
// - Non-PWM output modes: off, toggle, clear, set on match.
// - Fast PWM: clear on match set at bottom, or the inverse.
// - Phase-correct: clear up-match set down-match, or the inverse.
// - Compare equal to TOP in PWM: match ignored, action done at TOP.
// - Tick source: stop, undivided clock, or taps dividing 8, 64, 256, 1024.
// - Source 6 counts falling, source 7 rising edges of the count pin.
// - Count pin edges count even while the pin is an output.
// - Counter register is directly readable and writable.
// - Counter write blocks the compare match on the next tick.
// - Compare register is compared continuously for flag and waveform.
// - Compare interrupt needs enable, global enable and compare flag.
// - Overflow interrupt needs enable, global enable and overflow flag.
// - Compare flag sets on match, clears on vector or written one.
// - Overflow flag sets on overflow, clears on vector or written one.
// - Phase-correct overflow sets at direction change at zero.
// - Fast PWM counts bottom to max then restarts at bottom.
// - Phase-correct counts up, holds max one tick, counts down.
// - Count pin is synchronised and edge detected, about three cycles latency.
`timescale 1ns/1ps
module t8p_timer
	import t8p_pkg::*;
(
	input  wire logic              i_mclk,
	input  wire logic              i_rst,
	input  wire logic [T8P_AW-1:0] i_addr,
	input  wire logic [T8P_DW-1:0] i_wdata,
	input  wire logic              i_wr,
	input  wire logic              i_rd,
	input  wire logic              i_ext_count_pin,
	input  wire logic              i_global_irq_enable,
	input  wire logic              i_compare_vector_ack,
	input  wire logic              i_overflow_vector_ack,
	input  wire logic              i_port_out,
	input  wire logic              i_port_dir,
	output logic [T8P_DW-1:0]      o_rdata,
	output logic                   o_wave_out_pin,
	output logic                   o_wave_out_pin_oe,
	output logic                   o_compare_irq,
	output logic                   o_overflow_irq
);

	t8p_ctrl_t         ctrl_reg;
	t8p_ctrl_t         ctrl_next;
	logic [7:0]        count_reg;
	logic [7:0]        count_next;
	logic [7:0]        cmp_buf_reg;
	logic [7:0]        cmp_buf_next;
	logic [7:0]        cmp_act_reg;
	logic [7:0]        cmp_act_next;
	logic [1:0]        mask_reg;
	logic [1:0]        mask_next;
	logic [1:0]        flags_reg;
	logic [1:0]        flags_next;
	t8p_dir_t          dir_reg;
	t8p_dir_t          dir_next;
	logic              block_reg;
	logic              block_next;
	logic              wave_reg;
	logic              wave_next;
	logic [PSC_W-1:0]  psc_reg;
	logic [PSC_W-1:0]  psc_next;
	logic              ext_s1_reg;
	logic              ext_s2_reg;
	logic              ext_s3_reg;
	logic [7:0]        rdata_next;
	logic              pin_out_next;
	logic              cmp_irq_next;
	logic              ovf_irq_next;
	t8p_mode_t         mode;
	logic              is_pwm;
	logic              tick;
	logic              match;
	logic              force_hit;
	logic              ovf_event;
	logic              count_wr;

	// Applies a compare output action to the current waveform level.
	function automatic logic wave_action(input logic [1:0] com, input logic cur);
		logic res;
		res = cur;
		case (com)
			COM_TOGGLE: res = ~cur;
			COM_CLEAR:  res = 1'b0;
			COM_SET:    res = 1'b1;
			default:    res = cur;
		endcase
		return res;
	endfunction

	// True when the low bits of the prescaler are all ones.
	function automatic logic tap_hit(input logic [PSC_W-1:0] psc, input int bits);
		logic hit;
		hit = 1'b1;
		for (int k = 0; k < PSC_W; k++) begin
			if (k < bits && !psc[k]) begin
				hit = 1'b0;
			end
		end
		return hit;
	endfunction

	assign mode     = t8p_mode_t'({ctrl_reg.wgm_hi, ctrl_reg.wgm_lo});
	assign is_pwm   = (mode == MODE_PC_PWM) || (mode == MODE_FAST_PWM);
	assign count_wr = i_wr && (i_addr == A_COUNT);

	always_comb begin
		case (ctrl_reg.tick_source_sel)
			CS_STOP:     tick = 1'b0;
			CS_DIV1:     tick = 1'b1;
			CS_DIV8:     tick = tap_hit(psc_reg, TAP_DIV8);
			CS_DIV64:    tick = tap_hit(psc_reg, TAP_DIV64);
			CS_DIV256:   tick = tap_hit(psc_reg, TAP_DIV256);
			CS_DIV1024:  tick = tap_hit(psc_reg, TAP_DIV1024);
			CS_EXT_FALL: tick = ext_s3_reg && !ext_s2_reg;
			default:     tick = !ext_s3_reg && ext_s2_reg;
		endcase
	end

	assign match = (count_reg == cmp_act_reg) && !block_reg;

	assign force_hit = i_wr && (i_addr == A_CONTROL) && i_wdata[7] && !is_pwm;

	always_comb begin
		ctrl_next    = ctrl_reg;
		count_next   = count_reg;
		cmp_buf_next = cmp_buf_reg;
		cmp_act_next = cmp_act_reg;
		mask_next    = mask_reg;
		dir_next     = dir_reg;
		block_next   = block_reg;
		wave_next    = wave_reg;
		psc_next     = psc_reg + 1'b1;
		ovf_event    = 1'b0;
		flags_next   = flags_reg;
		if (tick) begin
			block_next = 1'b0;
			case (mode)
				MODE_NORMAL: begin
					count_next = count_reg + 1'b1;
					ovf_event  = (count_reg == COUNT_MAX);
					if (match) begin
						wave_next = wave_action(ctrl_reg.compare_output_mode, wave_reg);
					end
				end
				MODE_CLR_ON_M: begin
					count_next = (count_reg == cmp_act_reg) ? COUNT_BOTTOM : count_reg + 1'b1;
					ovf_event  = (count_reg == COUNT_MAX);
					if (match) begin
						wave_next = wave_action(ctrl_reg.compare_output_mode, wave_reg);
					end
				end
				MODE_FAST_PWM: begin
					count_next = count_reg + 1'b1;
					ovf_event  = (count_reg == COUNT_MAX);
					if (match && cmp_act_reg != COUNT_MAX && ctrl_reg.compare_output_mode[1]) begin
						wave_next = ctrl_reg.compare_output_mode[0];
					end
					if (count_reg == COUNT_MAX) begin
						cmp_act_next = cmp_buf_reg;
						// Top equal compare acts at top
						if (ctrl_reg.compare_output_mode[1]) begin
							wave_next = !ctrl_reg.compare_output_mode[0];
						end
					end
				end
				default: begin
					// Dual slope, max held one tick
					if (dir_reg == DIR_UP) begin
						if (count_reg == COUNT_MAX) begin
							dir_next     = DIR_DOWN;
							count_next   = count_reg - 1'b1;
							cmp_act_next = cmp_buf_reg;
						end else begin
							count_next = count_reg + 1'b1;
						end
					end else begin
						if (count_reg == COUNT_BOTTOM) begin
							dir_next   = DIR_UP;
							count_next = count_reg + 1'b1;
							ovf_event  = 1'b1;
						end else begin
							count_next = count_reg - 1'b1;
						end
					end
					// Up clears, down sets for non-inverting
					if (ctrl_reg.compare_output_mode[1]) begin
						if (cmp_act_reg == COUNT_MAX) begin
							if (count_reg == COUNT_MAX) begin
								wave_next = !ctrl_reg.compare_output_mode[0];
							end
						end else if (match) begin
							// A match at bottom acts as an up-counting match, so a zero compare stays inactive.
							wave_next = (dir_reg == DIR_UP || count_reg == COUNT_BOTTOM)
							            ? ctrl_reg.compare_output_mode[0]
							            : !ctrl_reg.compare_output_mode[0];
						end
					end
				end
			endcase
		end
		// Forced compare changes only the waveform
		if (force_hit) begin
			wave_next = wave_action(ctrl_reg.compare_output_mode, wave_reg);
		end
		if (i_wr) begin
			if (i_addr == A_CONTROL) begin
				ctrl_next = t8p_ctrl_t'(i_wdata);
				ctrl_next.force_compare_strobe = 1'b0;
			end else if (i_addr == A_COUNT) begin
				count_next = i_wdata;
				block_next = 1'b1;
			end else if (i_addr == A_COMPARE) begin
				cmp_buf_next = i_wdata;
				if (!is_pwm) begin
					cmp_act_next = i_wdata;
				end
			end else if (i_addr == A_IRQ_MASK) begin
				mask_next = i_wdata[1:0];
			end
		end
		if (i_wr && (i_addr == A_IRQ_FLAGS)) begin
			flags_next = flags_next & ~i_wdata[1:0];
		end
		if (i_compare_vector_ack) begin
			flags_next[BIT_CMP] = 1'b0;
		end
		if (tick && match) begin
			flags_next[BIT_CMP] = 1'b1;
		end
		if (i_overflow_vector_ack) begin
			flags_next[BIT_OVF] = 1'b0;
		end
		if (ovf_event) begin
			flags_next[BIT_OVF] = 1'b1;
		end
	end

	always_comb begin
		rdata_next = 8'h00;
		if (i_rd) begin
			if (i_addr == A_CONTROL) begin
				rdata_next = {1'b0, ctrl_reg[6:0]};
			end else if (i_addr == A_COUNT) begin
				rdata_next = count_reg;
			end else if (i_addr == A_COMPARE) begin
				rdata_next = cmp_buf_reg;
			end else if (i_addr == A_IRQ_MASK) begin
				rdata_next = {6'h00, mask_reg};
			end else if (i_addr == A_IRQ_FLAGS) begin
				rdata_next = {6'h00, flags_reg};
			end
		end
		pin_out_next = (ctrl_reg.compare_output_mode != COM_OFF) ? wave_reg : i_port_out;
		cmp_irq_next = mask_reg[BIT_CMP] && i_global_irq_enable && flags_reg[BIT_CMP];
		ovf_irq_next = mask_reg[BIT_OVF] && i_global_irq_enable && flags_reg[BIT_OVF];
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			ctrl_reg          <= t8p_ctrl_t'(CONTROL_RESET);
			count_reg         <= COUNT_RESET;
			cmp_buf_reg       <= COMPARE_RESET;
			cmp_act_reg       <= COMPARE_RESET;
			mask_reg          <= MASK_RESET;
			flags_reg         <= FLAGS_RESET;
			dir_reg           <= DIR_UP;
			block_reg         <= 1'b0;
			wave_reg          <= 1'b0;
			psc_reg           <= '0;
			o_rdata           <= 8'h00;
			o_wave_out_pin    <= 1'b0;
			o_wave_out_pin_oe <= 1'b0;
			o_compare_irq     <= 1'b0;
			o_overflow_irq    <= 1'b0;
		end else begin
			ctrl_reg          <= ctrl_next;
			count_reg         <= count_next;
			cmp_buf_reg       <= cmp_buf_next;
			cmp_act_reg       <= cmp_act_next;
			mask_reg          <= mask_next;
			flags_reg         <= flags_next;
			dir_reg           <= dir_next;
			block_reg         <= block_next;
			wave_reg          <= wave_next;
			psc_reg           <= psc_next;
			o_rdata           <= rdata_next;
			o_wave_out_pin    <= pin_out_next;
			o_wave_out_pin_oe <= i_port_dir;
			o_compare_irq     <= cmp_irq_next;
			o_overflow_irq    <= ovf_irq_next;
		end
	end

	// Pin sampled regardless of its direction
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			ext_s1_reg <= 1'b0;
			ext_s2_reg <= 1'b0;
			ext_s3_reg <= 1'b0;
		end else begin
			ext_s1_reg <= i_ext_count_pin;
			ext_s2_reg <= ext_s1_reg;
			ext_s3_reg <= ext_s2_reg;
		end
	end

	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_rst);

	force_reads_zero_a: assert property (i_rd && i_addr == A_CONTROL |=> !o_rdata[7])
		else $error("Force strobe read back as one.");

	force_no_flag_a: assert property (force_hit && !tick && !i_compare_vector_ack
		&& !i_overflow_vector_ack && !(i_wr && i_addr == A_IRQ_FLAGS)
		|=> flags_reg == $past(flags_reg) && count_reg == $past(count_reg))
		else $error("Forced compare touched flags or counter.");

	force_toggle_a: assert property (force_hit && !tick
		&& ctrl_reg.compare_output_mode == COM_TOGGLE |=> wave_reg != $past(wave_reg))
		else $error("Forced toggle did not change the waveform.");

	stopped_count_hold_a: assert property (ctrl_reg.tick_source_sel == CS_STOP && !count_wr
		|=> count_reg == $past(count_reg))
		else $error("Counter moved with no tick source.");

	fast_wrap_a: assert property (mode == MODE_FAST_PWM && tick && count_reg == COUNT_MAX
		&& !count_wr |=> count_reg == COUNT_BOTTOM && flags_reg[BIT_OVF])
		else $error("Fast PWM did not wrap with overflow.");

	pc_bottom_ovf_a: assert property (mode == MODE_PC_PWM && tick && dir_reg == DIR_DOWN
		&& count_reg == COUNT_BOTTOM && !count_wr |=> flags_reg[BIT_OVF] && dir_reg == DIR_UP)
		else $error("Phase-correct overflow missing at bottom.");

	cmp_irq_gate_a: assert property (##1 o_compare_irq
		== $past(mask_reg[BIT_CMP] && i_global_irq_enable && flags_reg[BIT_CMP]))
		else $error("Compare request does not follow its gating.");

	ovf_irq_gate_a: assert property (##1 o_overflow_irq
		== $past(mask_reg[BIT_OVF] && i_global_irq_enable && flags_reg[BIT_OVF]))
		else $error("Overflow request does not follow its gating.");

	write_blocks_match_a: assert property (count_wr ##1 tick && !i_wr
		|=> flags_reg[BIT_CMP] == $past(flags_reg[BIT_CMP] && !i_compare_vector_ack))
		else $error("Compare match not blocked after counter write.");

	set_wins_a: assert property (tick && match && i_wr && i_addr == A_IRQ_FLAGS
		&& i_wdata[BIT_CMP] |=> flags_reg[BIT_CMP])
		else $error("Flag clear beat a same-cycle set.");

	ext_rise_tick_a: assert property (ctrl_reg.tick_source_sel == CS_EXT_RISE && $rose(ext_s2_reg)
		&& !count_wr && mode == MODE_NORMAL |=> count_reg == $past(count_reg) + 8'h01)
		else $error("Rising count pin edge did not advance the counter.");
endmodule

// ### sim/t8p_timer_tb_top.sv
// Self-checking bench for the eight-bit timer: registers, ticks, flags and waveform.
`timescale 1ns/1ps
module t8p_timer_tb_top
	import t8p_pkg::*;
;
	logic       i_mclk                = 1'b0;
	logic       i_rst                 = 1'b1;
	logic [2:0] i_addr                = 3'h0;
	logic [7:0] i_wdata               = 8'h00;
	logic       i_wr                  = 1'b0;
	logic       i_rd                  = 1'b0;
	logic       i_ext_count_pin       = 1'b0;
	logic       i_global_irq_enable   = 1'b0;
	logic       i_compare_vector_ack  = 1'b0;
	logic       i_overflow_vector_ack = 1'b0;
	logic       i_port_out            = 1'b0;
	logic       i_port_dir            = 1'b0;
	logic [7:0] o_rdata;
	logic       o_wave_out_pin;
	logic       o_wave_out_pin_oe;
	logic       o_compare_irq;
	logic       o_overflow_irq;
	int         miscompares           = 0;
	int         num_checks            = 0;
	int         seed                  = 32'he112;
	int         divs[5]               = '{1, 8, 64, 256, 1024};
	int         h;
	logic [7:0] a;
	logic [7:0] b;
	logic [7:0] c;

	always #5 i_mclk = ~i_mclk;

	t8p_timer dut (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_addr(i_addr),
		.i_wdata(i_wdata),
		.i_wr(i_wr),
		.i_rd(i_rd),
		.i_ext_count_pin(i_ext_count_pin),
		.i_global_irq_enable(i_global_irq_enable),
		.i_compare_vector_ack(i_compare_vector_ack),
		.i_overflow_vector_ack(i_overflow_vector_ack),
		.i_port_out(i_port_out),
		.i_port_dir(i_port_dir),
		.o_rdata(o_rdata),
		.o_wave_out_pin(o_wave_out_pin),
		.o_wave_out_pin_oe(o_wave_out_pin_oe),
		.o_compare_irq(o_compare_irq),
		.o_overflow_irq(o_overflow_irq)
	);

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t ns: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [2:0] ad, input logic [7:0] d);
		@(posedge i_mclk);
		i_addr <= ad;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_mclk);
		i_wr <= 1'b0;
	endtask

	task automatic rd(input logic [2:0] ad, output logic [7:0] d);
		@(posedge i_mclk);
		i_addr <= ad;
		i_rd <= 1'b1;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge i_mclk);
	endtask

	// Number of high cycles in one waveform period.
	function automatic int pwm_hi(input logic pc, input logic inv, input logic [7:0] cv);
		int p;
		int hi;
		p = pc ? 510 : 256;
		hi = (cv == 8'hff) ? p : (pc ? 2 * cv : cv + 1);
		return inv ? p - hi : hi;
	endfunction

	task automatic conclude;
		$display("Checks %0d, mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		#1000000;
		miscompares++;
		conclude();
	end

	initial begin
		repeat (4) @(posedge i_mclk);
		i_rst <= 1'b0;
		for (int k = 0; k < 8; k++) begin
			rd(k[2:0], a);
			chk(a, 8'h00);
		end
		repeat (4) begin
			b = 8'($random(seed));
			wr(A_COUNT, b);
			rd(A_COUNT, a);
			chk(a, b);
			wr(A_COMPARE, ~b);
			rd(A_COMPARE, a);
			chk(a, ~b);
		end
		for (int s = 0; s < 6; s++) begin
			wr(A_CONTROL, 8'(s));
			rd(A_COUNT, a);
			cyc(s == 0 ? 40 : 10 * divs[s - 1] - 2);
			rd(A_COUNT, b);
			chk(b - a, s == 0 ? 8'h00 : 8'h0a);
		end
		@(posedge i_mclk);
		i_port_dir <= 1'b1;
		for (int s = 6; s < 8; s++) begin
			wr(A_CONTROL, 8'(s));
			cyc(4);
			rd(A_COUNT, a);
			repeat (3) begin
				for (int e = 0; e < 2; e++) begin
					@(posedge i_mclk);
					i_ext_count_pin <= ~i_ext_count_pin;
					rd(A_COUNT, b);
					chk(b, a);
					cyc(4);
					rd(A_COUNT, b);
					a = a + 8'(e == 7 - s);
					chk(b, a);
				end
			end
		end
		wr(A_CONTROL, 8'h00);
		wr(A_IRQ_FLAGS, 8'hff);
		wr(A_COUNT, 8'h00);
		wr(A_COMPARE, 8'h40);
		wr(A_CONTROL, 8'h01);
		cyc(300);
		wr(A_CONTROL, 8'h00);
		rd(A_IRQ_FLAGS, a);
		chk(a, 8'h03);
		wr(A_IRQ_FLAGS, 8'h00);
		rd(A_IRQ_FLAGS, a);
		chk(a, 8'h03);
		wr(A_IRQ_MASK, 8'hff);
		rd(A_IRQ_MASK, a);
		chk(a, 8'h03);
		cyc(2);
		#1 chk({6'h00, o_compare_irq, o_overflow_irq}, 8'h00);
		@(posedge i_mclk);
		i_global_irq_enable <= 1'b1;
		cyc(3);
		#1 chk({6'h00, o_compare_irq, o_overflow_irq}, 8'h03);
		wr(A_IRQ_MASK, 8'h02);
		cyc(2);
		#1 chk({6'h00, o_compare_irq, o_overflow_irq}, 8'h02);
		wr(A_IRQ_FLAGS, 8'h02);
		rd(A_IRQ_FLAGS, a);
		chk(a, 8'h01);
		@(posedge i_mclk);
		i_overflow_vector_ack <= 1'b1;
		@(posedge i_mclk);
		i_overflow_vector_ack <= 1'b0;
		rd(A_IRQ_FLAGS, a);
		chk(a, 8'h00);
		wr(A_COMPARE, 8'h80);
		for (int k = 0; k < 2; k++) begin
			wr(A_IRQ_FLAGS, 8'hff);
			wr(A_CONTROL, 8'h01);
			wr(A_COUNT, 8'h80 - 8'(2 * k));
			cyc(20);
			wr(A_CONTROL, 8'h00);
			rd(A_IRQ_FLAGS, a);
			chk(a, 8'(2 * k));
		end
		// Flag clear in the very cycle of a compare set.
		wr(A_COUNT, 8'h10);
		wr(A_COMPARE, 8'h12);
		wr(A_IRQ_FLAGS, 8'hff);
		wr(A_CONTROL, 8'h01);
		cyc(1);
		wr(A_IRQ_FLAGS, 8'h02);
		wr(A_CONTROL, 8'h00);
		rd(A_IRQ_FLAGS, a);
		chk(a, 8'h02);
		c = 8'($random(seed)) & 8'h1f | 8'h08;
		wr(A_COMPARE, c);
		wr(A_COUNT, 8'h00);
		wr(A_CONTROL, 8'h09);
		repeat (8) begin
			cyc($random(seed) & 15);
			rd(A_COUNT, a);
			chk(8'(a > c), 8'h00);
		end
		wr(A_CONTROL, 8'h00);
		wr(A_IRQ_FLAGS, 8'hff);
		for (int k = 1; k < 4; k++) begin
			wr(A_CONTROL, 8'(k << 4));
			cyc(2);
			#1 b = {7'h00, o_wave_out_pin};
			wr(A_CONTROL, 8'h80 | 8'(k << 4));
			cyc(2);
			#1 chk({7'h00, o_wave_out_pin}, (k == 1) ? b ^ 8'h01 : 8'(k - 2));
		end
		rd(A_CONTROL, a);
		chk(a, 8'h30);
		rd(A_IRQ_FLAGS, a);
		chk(a, 8'h00);
		wr(A_COUNT, 8'h05);
		wr(A_CONTROL, 8'h38);
		wr(A_CONTROL, 8'hb8);
		rd(A_COUNT, a);
		chk(a, 8'h05);
		wr(A_CONTROL, 8'h68);
		cyc(2);
		#1 b = {7'h00, o_wave_out_pin};
		wr(A_CONTROL, 8'he8);
		cyc(2);
		#1 chk({7'h00, o_wave_out_pin}, b);
		wr(A_CONTROL, 8'h00);
		for (int k = 0; k < 4; k++) begin
			@(posedge i_mclk);
			i_port_out <= k[0];
			i_port_dir <= k[1];
			cyc(2);
			#1 chk({6'h00, o_wave_out_pin_oe, o_wave_out_pin}, 8'(k));
		end
		for (int k = 0; k < 8; k++) begin
			c = k[2] ? 8'hff : ((k == 3) ? 8'h00 : 8'($random(seed)));
			wr(A_CONTROL, 8'h00);
			wr(A_COMPARE, c);
			wr(A_CONTROL, (k[0] ? 8'h40 : 8'h48) | (k[1] ? 8'h31 : 8'h21));
			cyc(1100);
			h = 0;
			repeat (k[0] ? 510 : 256) begin
				@(posedge i_mclk);
				#1 h += (o_wave_out_pin === 1'b1);
			end
			chk(8'(h != pwm_hi(k[0], k[1], c)), 8'h00);
		end
		conclude();
	end
endmodule
